// File: mrc_reset_ctrl.sv
// Reset controller: source combining, pin pulldown, watchdog clear and reset values
// Notes on behaviour
// - Pin pulldown for source length plus 2 cycles, 3 cycles minimum
// - Power-up holds reset 16 or 4064 cycles
// - Stay in reset while other sources persist
// - Power-up alone never drives pin pulldown
// - Watchdog timeout resets; zero write restarts it
// - Clear register write-only; read returns program byte
// - Writing one does not restart the watchdog counter; it keeps counting
// - Watchdog reset present per build parameter
// - Undervoltage input resets when enabled by parameter
// - Fetch outside program/working memory resets
// - Reset loads stack, mask, vector, clears latches
// - Directions, pulldown inhibits cleared; interrupt enable set
// - Core tick cleared; slowest periodic rate chosen
// - Any reset clears the watchdog counter
// - Both timer counters load fffc on reset
// - Timer enables, output level cleared; rest kept
// - Serial control and status cleared; data kept
// - Analog mux cleared except sample bit; rest cleared
// - Oscillator select chooses internal low-power oscillator
`timescale 1ns/1ps
`default_nettype none
`include "mrc_cfg.svh"

module mrc_reset_ctrl #(
    parameter bit          LONG_STAB    = 1'b1,     // Stabilization count choice
    parameter bit          WDOG_EN      = 1'b1,     // Watchdog reset present
    parameter bit          UV_EN        = 1'b1,     // Undervoltage reset present
    parameter int unsigned WDOG_TIMEOUT = `MRC_WDOG_TIMEOUT, // Cycles to timeout
    parameter int unsigned STAB_LONG    = `MRC_STAB_LONG,    // Long stabilization
    parameter logic [7:0]  ROM_BYTE     = `MRC_ROM_BYTE_RST  // Program byte, arbitrary
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [15:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 osc_active,
    input  wire logic                 reset_pin_in,
    output logic                      reset_pin_out,
    output logic                      reset_pin_oe_n,
    input  wire logic                 undervoltage_in,
    input  wire logic                 fetch_valid,
    input  wire logic [15:0]          fetch_addr,
    output logic                      internal_rst,
    output mrc_pkg::mrc_init_type     init_vals
);
    import mrc_pkg::*;

    // ****************************************************************
    // Constants
    // ****************************************************************
    localparam int unsigned STAB_CYC = LONG_STAB ? STAB_LONG : `MRC_STAB_SHORT;
    localparam int unsigned CW       = $clog2(STAB_LONG + 1) + 1;
    localparam int unsigned WW       = $clog2(WDOG_TIMEOUT + 1) + 1;
    localparam logic [CW-1:0] STAB_LAST = CW'(STAB_CYC - 1);
    localparam logic [WW-1:0] WDOG_LAST = WW'(WDOG_TIMEOUT - 1);
    localparam logic [2:0]    PULL_LAST = 3'(`MRC_PULL_MIN_CYC - 1);

    // ****************************************************************
    // Reset pin synchroniser, three stages
    // ****************************************************************
    logic [2:0] pin_sync_q;      // Stage 0 feeds stage 1 only
    logic       pin_low_q;       // Filtered pin level, 1 when pin is low

    // Shift the pin in; sync stage 0 is read only by stage 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync_q <= 3'h7;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], reset_pin_in};
        end
    end

    // A change counts once stages 1 and 2 agree
    wire pin_agree = (pin_sync_q[1] == pin_sync_q[2]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_low_q <= 1'b0;
        end else if (pin_agree) begin
            pin_low_q <= ~pin_sync_q[2];
        end
    end

    // ****************************************************************
    // Power-up sequencer
    // ****************************************************************
    mrc_state_type state_q;      // Sequencer state
    mrc_state_type state_d;
    logic [CW-1:0] stab_cnt_q;   // Stabilization count
    logic          others_active; // Any source other than power-up

    // Count only once the oscillator runs
    wire stab_done = (stab_cnt_q == STAB_LAST);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            MRC_ST_STAB: begin
                // End of count; stay held if others persist
                if (osc_active && stab_done) begin
                    state_d = others_active ? MRC_ST_WAIT_SRC : MRC_ST_RUN;
                end
            end
            MRC_ST_WAIT_SRC: begin
                if (!others_active) begin
                    state_d = MRC_ST_RUN;
                end
            end
            MRC_ST_RUN: begin
                state_d = MRC_ST_RUN;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= MRC_ST_STAB;
            stab_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            if (state_q == MRC_ST_STAB && osc_active && !stab_done) begin
                stab_cnt_q <= stab_cnt_q + CW'(1);
            end
        end
    end

    wire power_up_src = (state_q != MRC_ST_RUN);

    // ****************************************************************
    // Illegal opcode fetch detection
    // ****************************************************************
    wire in_prog = (fetch_addr >= `MRC_PROG_LO) && (fetch_addr <= `MRC_PROG_HI);
    wire in_work = (fetch_addr >= `MRC_WORK_LO) && (fetch_addr <= `MRC_WORK_HI);
    wire illegal_fetch = fetch_valid && !in_prog && !in_work && !internal_rst;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire apb_setup = psel && !penable;
    wire apb_acc   = psel && penable;
    wire hit_clear = (paddr == `MRC_WDOG_CLEAR_OFF);
    wire hit_ctrl  = (paddr == 16'(`MRC_CTRL_OFF));
    wire hit_stat  = (paddr == 16'(`MRC_STATUS_OFF));
    wire hit_cause = (paddr == 16'(`MRC_CAUSE_OFF));
    wire hit_any   = hit_clear || hit_ctrl || hit_stat || hit_cause;
    // Zero in the clear bit restarts; one is ignored
    wire wdog_kick = apb_acc && pwrite && hit_clear && !pwdata[`MRC_CLEAR_BIT];

    // ****************************************************************
    // Watchdog counter
    // ****************************************************************
    logic [WW-1:0] wdog_cnt_q;   // Timeout counter
    logic          wdog_to_q;    // Timeout flag, held until reset clears it
    logic          wdog_run_q;   // Software stop of the watchdog, reset on

    // Counter restarts on kick and on any reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_cnt_q <= '0;
            wdog_to_q  <= 1'b0;
        end else if (internal_rst) begin
            wdog_cnt_q <= '0;
            wdog_to_q  <= 1'b0;
        end else if (wdog_kick || !wdog_run_q) begin
            wdog_cnt_q <= '0;
        end else if (wdog_cnt_q == WDOG_LAST) begin
            wdog_cnt_q <= '0;
            wdog_to_q  <= WDOG_EN;
        end else begin
            wdog_cnt_q <= wdog_cnt_q + WW'(1);
        end
    end

    // ****************************************************************
    // Source combining and pin pulldown
    // ****************************************************************
    mrc_src_type src;
    assign src.pin          = pin_low_q;
    assign src.power_up     = power_up_src;
    assign src.watchdog     = wdog_to_q;
    assign src.undervoltage = UV_EN && undervoltage_in;
    assign src.illegal      = illegal_fetch;
    assign others_active    = src.pin || src.watchdog || src.undervoltage || src.illegal;
    // Only three sources may pull the pin
    wire pull_src = src.watchdog || src.undervoltage || src.illegal;

    logic [2:0] pull_cnt_q;      // Minimum pulldown length counter
    logic       pull_q;          // Pulldown active
    logic       rst_q;           // Registered internal reset
    logic       pull_prev_q;     // Pulldown as it was one cycle ago

    // Pull while the source lasts, at least three cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_q     <= 1'b0;
            pull_cnt_q <= 3'h0;
        end else if (pull_src) begin
            pull_q     <= 1'b1;
            pull_cnt_q <= 3'h0;
        end else if (pull_q && pull_cnt_q != PULL_LAST) begin
            pull_cnt_q <= pull_cnt_q + 3'h1;
        end else begin
            pull_q <= 1'b0;
        end
    end

    // Registered OR; release lands on a clock edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_q       <= 1'b1;
            pull_prev_q <= 1'b0;
        end else begin
            // Our own pulldown comes back through the pin synchroniser late;
            // bridging that gap keeps reset from pulsing twice
            rst_q       <= others_active || src.power_up || pull_q || pull_prev_q;
            pull_prev_q <= pull_q;
        end
    end

    // Illegal fetch is held in the pull, which keeps reset through it
    assign internal_rst   = rst_q || pull_q;
    assign reset_pin_out  = 1'b0;
    assign reset_pin_oe_n = ~pull_q;

    // ****************************************************************
    // Cause register, sticky, cleared by write of one
    // ****************************************************************
    logic [4:0] cause_q;         // Which sources fired
    wire  [4:0] cause_set = {src.pin, src.power_up, src.watchdog, src.undervoltage, src.illegal};
    wire        cause_wr  = apb_acc && pwrite && hit_cause;
    wire  [4:0] cause_clr = cause_wr ? pwdata[4:0] : 5'h00;

    // Set wins over a simultaneous clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_q <= 5'h08;
        end else begin
            cause_q <= (cause_q & ~cause_clr) | cause_set;
        end
    end

    // Control register: watchdog run bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_run_q <= 1'b1;
        end else if (apb_acc && pwrite && hit_ctrl) begin
            wdog_run_q <= pwdata[0];
        end
    end

    // ****************************************************************
    // APB read data, registered at setup
    // ****************************************************************
    logic [31:0] rdata_q;        // Read word
    logic        err_q;          // Unmapped access flag
    wire  [31:0] rd_mux = hit_clear ? {24'h0, ROM_BYTE} :
                          hit_ctrl  ? {31'h0, wdog_run_q} :
                          hit_stat  ? {29'h0, internal_rst, pull_q, power_up_src} :
                          hit_cause ? {27'h0, cause_q} : 32'h0;

    // Capture read data in the setup cycle; access ends next cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0;
            err_q   <= 1'b0;
        end else if (apb_setup) begin
            rdata_q <= pwrite ? 32'h0 : rd_mux;
            err_q   <= !hit_any;
        end
    end

    assign prdata  = rdata_q;
    assign pready  = 1'b1;
    assign pslverr = apb_acc && err_q;

    // ****************************************************************
    // Reset values presented to the core and peripherals
    // ****************************************************************
    assign init_vals.stack_ptr                = `MRC_SP_RST;
    assign init_vals.irq_mask                 = 1'b1;
    assign init_vals.vector_hi_addr           = `MRC_VEC_HI;
    assign init_vals.vector_lo_addr           = `MRC_VEC_LO;
    assign init_vals.stop_latch_clr           = internal_rst;
    assign init_vals.wait_latch_clr           = internal_rst;
    // Interrupt enable set, osc select high=1 low=0; directions cleared by reset
    assign init_vals.irq_status_control_reg   = `MRC_IRQ_STATUS_CONTROL_REG_RST;
    assign init_vals.core_tick_status_control = `MRC_CORE_TICK_STATUS_CONTROL_RST;
    assign init_vals.timer_count              = `MRC_TMR_RST;
    assign init_vals.alt_count                = `MRC_TMR_RST;
    assign init_vals.analog_mux_reg           = `MRC_ANALOG_MUX_REG_RST;
    // Peripherals clear direction, pulldown inhibit, timer enables, output
    // level, serial control/status, analog control/status while internal_rst
    // is high, and keep their data/capture/compare registers.

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking mrc_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    pull_min_a: assert property ($rose(pull_q) |-> pull_q [*3])
        else $error("pulldown shorter than three cycles");
    pull_src_a: assert property (pull_src |=> !reset_pin_oe_n)
        else $error("pulldown missing for source");
    por_nopull_a: assert property (!pull_src && !$past(pull_src) && !$past(pull_src, 2)
                                   && !$past(pull_src, 3) |-> reset_pin_oe_n)
        else $error("pulldown without a pulling source");
    stab_hold_a: assert property (power_up_src |=> internal_rst)
        else $error("reset released during power-up");
    others_hold_a: assert property (state_q == MRC_ST_WAIT_SRC |-> ##1 internal_rst)
        else $error("reset released with source active");
    kick_one_a: assert property (apb_acc && pwrite && hit_clear && pwdata[0] && !internal_rst
                                 && wdog_run_q && wdog_cnt_q < WDOG_LAST
                                 |=> wdog_cnt_q == $past(wdog_cnt_q) + WW'(1))
        else $error("one write disturbed watchdog");
    kick_zero_a: assert property (wdog_kick |=> wdog_cnt_q == '0)
        else $error("zero write did not restart watchdog");
    wdog_clr_a: assert property (internal_rst |=> wdog_cnt_q == '0)
        else $error("watchdog not cleared by reset");
    illegal_rst_a: assert property (illegal_fetch |=> internal_rst ##1 internal_rst)
        else $error("illegal fetch did not reset");
    uv_rst_a: assert property (src.undervoltage |=> internal_rst)
        else $error("undervoltage did not reset");
    rom_read_a: assert property (apb_setup && !pwrite && hit_clear |=> prdata == {24'h0, ROM_BYTE})
        else $error("clear register read returned state");

    por_done_c: cover property (state_q == MRC_ST_STAB ##1 state_q == MRC_ST_RUN);
    wait_src_c: cover property (state_q == MRC_ST_WAIT_SRC ##1 state_q == MRC_ST_RUN);
    wdog_to_c:  cover property ($rose(wdog_to_q));
    illegal_c:  cover property (illegal_fetch);

endmodule

`default_nettype wire

// File: mrc_cfg.svh
// Constants of the reset controller: offsets, field positions, reset values, timing
`ifndef MRC_CFG_SVH
`define MRC_CFG_SVH

// ********************************************************************
// Register offsets (APB byte addresses)
// ********************************************************************
`define MRC_WDOG_CLEAR_OFF   16'h1ff0
`define MRC_CTRL_OFF         12'h000
`define MRC_STATUS_OFF       12'h004
`define MRC_CAUSE_OFF        12'h008

// ********************************************************************
// Field positions and reset values
// ********************************************************************
`define MRC_CLEAR_BIT        0
`define MRC_ROM_BYTE_RST     8'h00
`define MRC_TMR_RST          16'hfffc
`define MRC_ANALOG_MUX_REG_RST         8'h80
`define MRC_IRQ_STATUS_CONTROL_REG_RST         8'h90
`define MRC_CORE_TICK_STATUS_CONTROL_RST        8'h03
`define MRC_VEC_HI           16'h1ffe
`define MRC_VEC_LO           16'h1fff
`define MRC_SP_RST           8'hff

// ********************************************************************
// Address map used by the illegal-fetch check
// ********************************************************************
`define MRC_PROG_LO          16'h0700
`define MRC_PROG_HI          16'h1fff
`define MRC_WORK_LO          16'h0020
`define MRC_WORK_HI          16'h00ff

// ********************************************************************
// Timing counts in bus cycles
// ********************************************************************
`define MRC_PULL_MIN_CYC     3
`define MRC_STAB_SHORT       16
`define MRC_STAB_LONG        4064
`define MRC_WDOG_TIMEOUT     65536

`endif

// File: mrc_pkg.sv
// Types shared by the reset controller
package mrc_pkg;

    // Raw reset sources, one bit each
    typedef struct packed {
        logic pin;
        logic power_up;
        logic watchdog;
        logic undervoltage;
        logic illegal;
    } mrc_src_type;

    // Reset values presented to the core and peripherals
    typedef struct packed {
        logic [7:0]  stack_ptr;
        logic        irq_mask;
        logic [15:0] vector_lo_addr;
        logic [15:0] vector_hi_addr;
        logic        stop_latch_clr;
        logic        wait_latch_clr;
        logic [7:0]  irq_status_control_reg;
        logic [7:0]  core_tick_status_control;
        logic [15:0] timer_count;
        logic [15:0] alt_count;
        logic [7:0]  analog_mux_reg;
    } mrc_init_type;

    // Power-up sequencer states
    typedef enum logic [1:0] {
        MRC_ST_STAB,
        MRC_ST_WAIT_SRC,
        MRC_ST_RUN
    } mrc_state_type;

endpackage

// File: mrc_pin_agent.sv
// Reset pin wire with pull-up, and an outside agent that can pull it low
`timescale 1ns/1ps
`default_nettype none

module mrc_pin_agent (
    input  wire logic pclk,           // Bus clock
    input  wire logic ext_req,        // Bench asks the agent to pull the pin
    input  wire logic reset_pin_out,  // Device drive level
    input  wire logic reset_pin_oe_n, // Device drive enable, low while driving
    output logic      pin_level       // Resolved level of the wire
);
    // ****************************************
    // Outside agent
    // ****************************************
    logic [1:0] hold_q = 2'd0; // Cycles still owed to a request

    // Stretch each request so the pin stays low for two more whole cycles
    always_ff @(posedge pclk) begin
        if (ext_req) begin
            hold_q <= 2'd2;
        end else if (hold_q != 2'd0) begin
            hold_q <= hold_q - 2'd1;
        end
    end

    // Pull-up gives a high level only when nobody pulls low
    assign pin_level = !(ext_req || (hold_q != 2'd0) || (!reset_pin_oe_n && !reset_pin_out));
endmodule

`default_nettype wire

// File: test_mcu_reset_controller.sv
// Self-checking bench for the reset controller
`timescale 1ns/1ps
`default_nettype none

module test_mcu_reset_controller;
    import mrc_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    localparam int STAB = 40; // Shortened stabilization count
    localparam int WDT  = 64; // Shortened watchdog timeout
    logic         pclk, presetn, psel, penable, pwrite, osc_active, undervoltage_in;
    logic         fetch_valid, ext_req, pin_level, pready, pslverr, err, rst_prev;
    logic         reset_pin_out, reset_pin_oe_n, internal_rst, legal;
    logic [15:0]  paddr, fetch_addr, a;
    logic [31:0]  pwdata, prdata, seed, rd;
    mrc_init_type init_vals;
    int           fail_count = 0, n_compared = 0, run = 0, last_run = 0;
    int           pulls = 0, rises = 0, cyc = 0, n, p0, r0, t0;
    logic [15:0]  edge_q[$] = '{16'h0020, 16'h00ff, 16'h0700, 16'h1fff, 16'h001f,
                                16'h0100, 16'h06ff, 16'h2000, 16'hffff};

    mrc_reset_ctrl #(.WDOG_TIMEOUT(WDT), .STAB_LONG(STAB), .ROM_BYTE(8'h5a)) i_mrc_reset_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_active(osc_active), .reset_pin_in(pin_level), .reset_pin_out(reset_pin_out),
        .reset_pin_oe_n(reset_pin_oe_n), .undervoltage_in(undervoltage_in),
        .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .internal_rst(internal_rst),
        .init_vals(init_vals));
    mrc_pin_agent i_mrc_pin_agent (.pclk(pclk), .ext_req(ext_req), .reset_pin_out(reset_pin_out),
        .reset_pin_oe_n(reset_pin_oe_n), .pin_level(pin_level));

    // 40 MHz bus clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Monitor at the falling edge, where outputs have settled
    always @(negedge pclk) begin
        cyc++;
        if (reset_pin_oe_n === 1'b0) begin
            run++;
        end else if (run != 0) begin
            last_run = run; // Length of the pulldown pulse just ended
            pulls++;
            run = 0;
        end
        if (internal_rst === 1'b1 && rst_prev !== 1'b1) rises++;
        rst_prev = internal_rst;
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [15:0] ad, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 16) check("pready_bound", 32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Restart the watchdog with a zero clear bit and random upper bits
    task automatic kick();
        seed = xs(seed);
        apb(1'b1, 16'h1ff0, {seed[31:1], 1'b0});
    endtask

    task automatic wait_rst(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (internal_rst !== lvl) begin
            @(negedge pclk);
            cnt++;
            if (cnt > lim) begin
                check("wait_bound", 32'h0, 32'h1);
                report_and_stop();
            end
        end
    endtask

    task automatic done(input string name);
        $display("test %s done: %0d compared, %0d mismatches", name, n_compared, fail_count);
    endtask

    // A long hang ends the run as a mismatch
    initial begin
        #2500000;
        fail_count++;
        report_and_stop();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {psel, penable, pwrite, osc_active, undervoltage_in, fetch_valid, ext_req} = '0;
        paddr = '0;
        fetch_addr = '0;
        pwdata = '0;
        presetn = 1'b0;
        seed = 32'hc049;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Oscillator starts late: the count must not run before it
        repeat (5) @(posedge pclk);
        check("rst_no_osc", 32'(internal_rst), 32'h1);
        check("stack", 32'(init_vals.stack_ptr), 32'hff);
        check("irq_mask", 32'(init_vals.irq_mask), 32'h1);
        check("vec", {init_vals.vector_hi_addr, init_vals.vector_lo_addr}, 32'h1ffe1fff);
        check("latch_clr", 32'({init_vals.stop_latch_clr, init_vals.wait_latch_clr}), 32'h3);
        check("irq_status_control_reg", 32'(init_vals.irq_status_control_reg), 32'h90);
        check("tick", 32'(init_vals.core_tick_status_control), 32'h03);
        check("timers", {init_vals.timer_count, init_vals.alt_count}, 32'hfffcfffc);
        check("analog_mux_reg", 32'(init_vals.analog_mux_reg), 32'h80);
        osc_active <= 1'b1;
        wait_rst(1'b0, 100, n);
        check("stab_len", 32'(n >= STAB && n <= STAB + 4), 32'h1);
        check("por_no_pull", 32'(pulls), 32'h0);
        check("latch_off", 32'(init_vals.stop_latch_clr), 32'h0);
        done("power_up");
        // Regular zero writes keep the watchdog quiet
        r0 = rises;
        for (int i = 0; i < 6; i++) begin
            kick();
            repeat (40) @(posedge pclk);
        end
        check("wdog_quiet", 32'(rises), 32'(r0));
        apb(1'b0, 16'h1ff0, 32'h0);
        check("clr_read", rd, 32'h5a);
        check("clr_err", 32'(err), 32'h0);
        apb(1'b0, 16'h0100, 32'h0);
        check("unmapped_err", 32'(err), 32'h1);
        // Writes of one do not restart it, so it times out
        kick();
        t0 = cyc;
        p0 = pulls;
        for (int i = 0; i < 40 && internal_rst !== 1'b1; i++) apb(1'b1, 16'h1ff0, 32'h1);
        check("wdog_time", 32'(cyc - t0 >= WDT - 2 && cyc - t0 <= WDT + 8), 32'h1);
        wait_rst(1'b0, 40, n);
        check("wdog_pull", 32'(pulls - p0 == 1 && last_run >= 3 && last_run <= 4), 32'h1);
        r0 = rises;
        repeat (WDT - 10) @(posedge pclk);
        check("wdog_restart", 32'(rises), 32'(r0));
        done("watchdog");
        // Fetch addresses: boundary table first, then random
        for (int i = 0; i < 20; i++) begin
            seed = xs(seed);
            a = seed[16] ? 16'h0700 + (seed[15:0] % 16'h1900) : seed[15:0];
            if (i < 9) a = edge_q[i];
            legal = (a >= 16'h0700 && a <= 16'h1fff) || (a >= 16'h0020 && a <= 16'h00ff);
            kick();
            p0 = pulls;
            @(posedge pclk);
            fetch_valid <= 1'b1;
            fetch_addr <= a;
            @(posedge pclk);
            fetch_valid <= 1'b0;
            repeat (4) @(negedge pclk);
            check("fetch_rst", 32'(internal_rst), 32'(!legal));
            if (!legal) begin
                wait_rst(1'b0, 40, n);
                check("fetch_pull", 32'(pulls - p0 == 1 && last_run >= 3 && last_run <= 4), 32'h1);
            end
        end
        done("fetch");
        // Undervoltage outlasting the stabilization count
        @(posedge pclk);
        presetn <= 1'b0;
        undervoltage_in <= 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (STAB + 20) @(posedge pclk);
        check("uv_holds", 32'(internal_rst), 32'h1);
        undervoltage_in <= 1'b0;
        wait_rst(1'b0, 30, n);
        check("uv_pull", 32'(last_run >= STAB + 20), 32'h1);
        done("undervoltage");
        // Short outside request on the pin: reset without pulldown
        kick();
        p0 = pulls;
        @(posedge pclk);
        ext_req <= 1'b1;
        @(posedge pclk);
        ext_req <= 1'b0;
        wait_rst(1'b1, 10, n);
        wait_rst(1'b0, 30, n);
        check("pin_no_pull", 32'(pulls), 32'(p0));
        done("pin");
        // Cause bits since the mid-run reset: pin, power-up, undervoltage
        apb(1'b0, 16'h0008, 32'h0);
        check("cause", rd, 32'h1a);
        apb(1'b1, 16'h0008, 32'h1f);
        apb(1'b0, 16'h0008, 32'h0);
        check("cause_clr", rd, 32'h0);
        done("cause");
        report_and_stop();
    end
endmodule

`default_nettype wire
